//--- logic/bmg_cfg.svh
`ifndef BMG_CFG_SVH
`define BMG_CFG_SVH
// Clock rate in Hz; one cycle is 50 ns.
`define BMG_CLK_HZ        20000000
// Internal timebase tick rate in Hz.
`define BMG_TICK_HZ       10240
`define BMG_TICK_DIV      (`BMG_CLK_HZ / `BMG_TICK_HZ)
// Watchdog periods in timebase ticks: 100 ms and 1.6 s at 10.24 kHz.
`define BMG_SHORT_MS      100
`define BMG_LONG_MS       1600
`define BMG_SHORT_TICKS   (`BMG_SHORT_MS * `BMG_TICK_HZ / 1000)
`define BMG_LONG_TICKS    (`BMG_LONG_MS * `BMG_TICK_HZ / 1000)
// Watchdog periods in external timebase edges.
`define BMG_EXT_SHORT     1024
`define BMG_EXT_LONG      4096
`define BMG_CNT_W         16
`endif

//--- logic/bmg_pkg.sv
package bmg_pkg;
  typedef logic [15:0] bmg_cnt_t;
  typedef enum logic [1:0] {
    BMG_LONG_WAIT  = 2'b00,
    BMG_SHORT_RUN  = 2'b01,
    BMG_EXPIRED    = 2'b11
  } bmg_wd_state_t;
endpackage

//--- logic/bmg_sync.sv
`timescale 1ns/1ps
module bmg_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

//--- logic/bmg_top.sv
`timescale 1ns/1ps
`include "bmg_cfg.svh"
// Contract
// RULE1 - The warning output is low while the sensed supply is below the reference and high otherwise.
// RULE2 - The comparison is noninverting, above the reference gives high warning output.
// RULE3 - In backup mode the comparison is ignored and the warning output is held low.
// RULE4 - In backup mode the high reset output is high and the low reset output is low.
// RULE5 - In backup mode the timeout flag and on-battery outputs are held high.
// RULE6 - In backup mode kick transitions have no effect on the watchdog.
// RULE7 - In backup mode the chip-select input affects no output.
// RULE8 - In backup mode the gated chip-select output is forced high.
// RULE9 - A floating kick input disables the watchdog and no timeout resets occur.
// RULE10 - Timebase select low uses the external timebase, high uses the internal oscillator.
// RULE11 - With the internal oscillator the timeout is 100 ms or 1.6 s chosen by the timebase input; code uses 1.6 s until a kick follows reset or expiry.
// RULE12 - In backup mode the low-supply status output is held low.
// RULE13 - In backup mode timebase and timebase-select inputs are ignored.
// RULE14 - Backup mode is entered when the main supply is below the battery.
// RULE15 - The timeout flag goes low on expiry and returns high on the next kick transition.
module bmg_top (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_supply_sense_in,
  input  wire logic i_main_below_batt,
  input  wire logic i_supply_low,
  input  wire logic i_reset_req,
  input  wire logic i_watchdog_kick_in,
  input  wire logic i_kick_floating,
  input  wire logic i_cs_n,
  input  wire logic i_timebase_select,
  input  wire logic i_timebase_in,
  output logic      o_early_warning_n,
  output logic      o_reset,
  output logic      o_reset_n,
  output logic      o_low_supply_n,
  output logic      o_timeout_flag_n,
  output logic      o_on_battery,
  output logic      o_cs_n,
  output logic      o_wd_reset
);
  import bmg_pkg::*;

  // Pins are asynchronous, so every one passes two flip-flops first.
  logic [9:0] pin_s;
  bmg_sync #(.W(10)) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({
      i_supply_sense_in,
      i_main_below_batt,
      i_supply_low,
      i_reset_req,
      i_watchdog_kick_in,
      i_kick_floating,
      i_cs_n,
      i_timebase_select,
      i_timebase_in,
      1'b0
    }),
    .o_sync  (pin_s)
  );

  wire sense_above = pin_s[9];
  wire backup      = pin_s[8];                                 // RULE14
  wire low_supply  = pin_s[7];
  wire rst_req     = pin_s[6];
  wire kick        = pin_s[5];
  wire kick_float  = pin_s[4];
  wire cs_in_n     = pin_s[3];
  wire tb_sel      = pin_s[2];
  wire tb_in       = pin_s[1];

  logic          kick_q;
  logic          tb_q;
  logic [15:0]   div_q;
  bmg_cnt_t      cnt_q;
  bmg_wd_state_t st_q;
  logic          wd_pulse_q;

  // Backup stops the watchdog and clears its count, so kick, timebase and select do nothing.
  wire wd_live   = ~backup & ~rst_req;                         // RULE6 RULE13
  wire kick_edge = wd_live & (kick ^ kick_q);                  // RULE6
  wire div_done  = (div_q == 16'(`BMG_TICK_DIV - 1));
  wire ext_edge  = tb_in & ~tb_q;
  // Select low means external timebase edges clock the timer.
  wire tick      = tb_sel ? div_done : ext_edge;               // RULE10
  // A kick input that floats disables the watchdog entirely.
  wire wd_off    = kick_float;                                 // RULE9

  function automatic bmg_cnt_t wd_limit(input logic long_p, input logic sel, input logic tin);
    if (!sel)
      wd_limit = long_p ? 16'(`BMG_EXT_LONG) : 16'(`BMG_EXT_SHORT);
    else if (long_p || tin)
      wd_limit = 16'(`BMG_LONG_TICKS);                         // RULE11
    else
      wd_limit = 16'(`BMG_SHORT_TICKS);                        // RULE11
  endfunction

  // The period after any watchdog reset is the long one, so firmware has time to start again.
  wire bmg_cnt_t limit  = wd_limit(st_q != BMG_SHORT_RUN, tb_sel, tb_in);
  wire           expire = wd_live & ~wd_off & tick & (cnt_q >= limit - 16'h0001);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= kick;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tb_q <= 1'b0;
    end else begin
      tb_q <= tb_in;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_done ? 16'h0000 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q      <= 16'h0000;
      st_q       <= BMG_LONG_WAIT;
      wd_pulse_q <= 1'b0;
    end else begin
      wd_pulse_q <= expire;
      if (!wd_live || wd_off) begin
        cnt_q <= 16'h0000;
        if (rst_req)
          st_q <= BMG_LONG_WAIT;
      end else if (kick_edge) begin
        cnt_q <= 16'h0000;
        st_q  <= BMG_SHORT_RUN;                                // RULE15
      end else if (expire) begin
        cnt_q <= 16'h0000;
        st_q  <= BMG_EXPIRED;                                  // RULE15
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // Outputs are registered; the backup forcing sits in the next-value terms.
  wire warn_d = backup ? 1'b0 : sense_above;                   // RULE1 RULE2 RULE3
  wire rst_d  = backup | rst_req | expire;                     // RULE4
  wire low_d  = backup ? 1'b0 : ~low_supply;                   // RULE12
  wire to_d   = backup | (st_q != BMG_EXPIRED) | kick_edge;    // RULE5 RULE15
  wire cs_d   = backup | rst_req | cs_in_n;                    // RULE7 RULE8

  // Each output has a flop of its own, so no pin can glitch while the inputs settle.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_early_warning_n <= 1'b0;
    end else begin
      o_early_warning_n <= warn_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reset <= 1'b1;
    end else begin
      o_reset <= rst_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reset_n <= 1'b0;
    end else begin
      o_reset_n <= ~rst_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_low_supply_n <= 1'b0;
    end else begin
      o_low_supply_n <= low_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_timeout_flag_n <= 1'b1;
    end else begin
      o_timeout_flag_n <= to_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_on_battery <= 1'b0;
    end else begin
      o_on_battery <= backup;                                  // RULE5
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cs_n <= 1'b1;
    end else begin
      o_cs_n <= cs_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wd_reset <= 1'b0;
    end else begin
      o_wd_reset <= wd_pulse_q;
    end
  end
endmodule

//--- dv/bmg_asserts.sv
`timescale 1ns/1ps
module bmg_asserts (
  input wire logic i_clk, i_reset, i_supply_sense_in, i_main_below_batt, i_supply_low,
  input wire logic i_reset_req, i_kick_floating, i_cs_n, o_early_warning_n, o_reset,
  input wire logic o_reset_n, o_low_supply_n, o_timeout_flag_n, o_on_battery, o_cs_n, o_wd_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Five samples cover both synchroniser flops and the output register.
  sequence s_bk; i_main_below_batt[*5]; endsequence
  sequence s_up; (!i_main_below_batt && !i_supply_low && !i_reset_req)[*5]; endsequence
  property p_warn_bk; s_bk |-> !o_early_warning_n; endproperty
  a_warn_bk: assert property (p_warn_bk) else $error("warning not low");
  property p_rst_bk; s_bk |-> o_reset && !o_reset_n; endproperty
  a_rst_bk: assert property (p_rst_bk) else $error("reset not forced");
  property p_flag_bk; s_bk |-> o_timeout_flag_n && o_on_battery; endproperty
  a_flag_bk: assert property (p_flag_bk) else $error("flags not high");
  property p_cs_bk; s_bk |-> o_cs_n; endproperty
  a_cs_bk: assert property (p_cs_bk) else $error("chip select not blocked");
  property p_low_bk; s_bk |-> !o_low_supply_n; endproperty
  a_low_bk: assert property (p_low_bk) else $error("low supply not low");
  property p_warn;
    (!i_main_below_batt && $stable(i_supply_sense_in))[*5] |-> o_early_warning_n == i_supply_sense_in;
  endproperty
  a_warn: assert property (p_warn) else $error("warning wrong");
  property p_cs; s_up and $stable(i_cs_n)[*5] |-> o_cs_n == i_cs_n; endproperty
  a_cs: assert property (p_cs) else $error("chip select not passed");
  property p_flt; i_kick_floating[*5] |-> !o_wd_reset; endproperty
  a_flt: assert property (p_flt) else $error("timeout while floating");
endmodule

//--- dv/bmg_host.sv
`timescale 1ns/1ps
module bmg_host (
  input  wire logic i_clk,
  input  wire logic i_go,
  output logic      o_kick
);
  initial o_kick = 1'b0;
  always @(posedge i_clk) if (i_go) o_kick <= !o_kick;
endmodule

//--- dv/bmg_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module bmg_top_bench;
  logic i_clk = 0, i_reset = 1, i_supply_sense_in = 1, i_main_below_batt = 0, i_supply_low = 0;
  logic i_reset_req = 0, i_kick_floating = 0, i_cs_n = 1, i_timebase_select = 0, i_timebase_in = 0;
  logic i_watchdog_kick_in, go = 0, o_early_warning_n, o_reset, o_reset_n, o_low_supply_n;
  logic o_timeout_flag_n, o_on_battery, o_cs_n, o_wd_reset;
  logic [1:0] div = 2'h0;
  int failures = 0, check_count = 0;
  always #25 i_clk = ~i_clk;
  // The timebase runs slow enough that the synchroniser sees every edge.
  always @(posedge i_clk) begin
    div <= div + 2'h1;
    if (div == 2'h0) i_timebase_in <= ~i_timebase_in;
  end
  bmg_host i_bmg_host (.i_clk, .i_go(go), .o_kick(i_watchdog_kick_in));
  bmg_top i_bmg_top (.i_clk, .i_reset, .i_supply_sense_in, .i_main_below_batt, .i_supply_low,
    .i_reset_req, .i_watchdog_kick_in, .i_kick_floating, .i_cs_n, .i_timebase_select,
    .i_timebase_in, .o_early_warning_n, .o_reset, .o_reset_n, .o_low_supply_n,
    .o_timeout_flag_n, .o_on_battery, .o_cs_n, .o_wd_reset);
  task automatic step(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_warn;
    @(posedge i_clk) i_supply_sense_in <= 1'b0;
    step(5);
    `CHK(o_early_warning_n, 1'b0)
    @(posedge i_clk) i_supply_sense_in <= 1'b1;
    step(5);
    `CHK(o_early_warning_n, 1'b1)
  endtask
  task automatic t_cs;
    @(posedge i_clk) i_cs_n <= 1'b0;
    step(5);
    `CHK(o_cs_n, 1'b0)
    @(posedge i_clk) i_cs_n <= 1'b1;
    step(5);
    `CHK(o_cs_n, 1'b1)
  endtask
  task automatic t_wd;
    int n = 0;
    while (o_wd_reset !== 1'b1 && n < 40000) begin step(1); n++; end
    `CHK(o_wd_reset, 1'b1)
    step(3);
    `CHK(o_timeout_flag_n, 1'b0)
    @(posedge i_clk) go <= 1'b1;
    @(posedge i_clk) go <= 1'b0;
    step(5);
    `CHK(o_timeout_flag_n, 1'b1)
  endtask
  task automatic t_bk;
    @(posedge i_clk) begin
      i_main_below_batt <= 1'b1;
      i_cs_n <= 1'b0;
      i_kick_floating <= 1'b1;
      i_timebase_select <= 1'b1;
      go <= 1'b1;
    end
    step(6);
    `CHK({o_early_warning_n, o_reset, o_reset_n, o_low_supply_n}, 4'h4)
    `CHK({o_timeout_flag_n, o_on_battery, o_cs_n, o_wd_reset}, 4'he)
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    t_warn;
    t_cs;
    t_wd;
    t_bk;
    stop_test;
  end
  initial begin
    #3ms;
    failures++;
    stop_test;
  end
endmodule
bind bmg_top bmg_asserts i_bmg_asserts (.i_clk, .i_reset, .i_supply_sense_in, .i_main_below_batt,
  .i_supply_low, .i_reset_req, .i_kick_floating, .i_cs_n, .o_early_warning_n, .o_reset,
  .o_reset_n, .o_low_supply_n, .o_timeout_flag_n, .o_on_battery, .o_cs_n, .o_wd_reset);
